// ===== rtl/bal_pkg.sv
// Shared constants and types of the byte ALU datapath.
// Assumes one core clock and that the decoder presents one operation a time.
package bal_pkg;

  localparam int DATA_W = 8;
  localparam int WORD_W = 16;

  // Operation codes presented by the instruction decoder.
  typedef enum logic [4:0] {
    op_add_regs = 5'h00,
    op_add_carry = 5'h01,
    op_word_plus_immediate = 5'h02,
    op_diff_regs = 5'h03,
    op_difference_immediate = 5'h04,
    op_difference_with_borrow = 5'h05,
    op_difference_borrow_immediate = 5'h06,
    op_word_minus_immediate = 5'h07,
    op_and_regs = 5'h08,
    op_conjunction_immediate = 5'h09,
    op_or_regs = 5'h0a,
    op_disjunction_immediate = 5'h0b,
    op_bitwise_xor_regs = 5'h0c,
    op_invert_all_bits = 5'h0d,
    op_arithmetic_inverse = 5'h0e,
    op_set_selected_bits = 5'h0f,
    op_clear_selected_bits = 5'h10,
    op_increment = 5'h11,
    op_minus_one = 5'h12,
    op_self_check_flags = 5'h13,
    op_zero_register = 5'h14,
    op_all_ones_load = 5'h15,
    op_product_unsigned = 5'h16,
    op_product_signed = 5'h17,
    op_product_mixed_sign = 5'h18,
    op_product_fractional = 5'h19
  } bal_op_t;

  // Two-cycle operations spend one extra state; the codes differ in one bit.
  typedef enum logic {
    st_idle = 1'b0,
    st_second = 1'b1
  } bal_state_t;

  // Where the result must be written by the register file.
  typedef enum logic [1:0] {
    dst_none = 2'h0,
    dst_reg = 2'h1,
    dst_pair = 2'h2,
    dst_product_result_pair = 2'h3
  } bal_dest_t;

  typedef enum logic [1:0] {
    mk_unsigned = 2'h0,
    mk_signed = 2'h1,
    mk_mixed = 2'h2,
    mk_fraction = 2'h3
  } bal_mkind_t;

  // Flag positions in the status vector.
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_W = 6;

  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [5:0] MASK_NONE = 6'h00;
  localparam logic [5:0] MASK_ARITH = 6'h2f;
  localparam logic [5:0] MASK_WORD = 6'h1f;
  localparam logic [5:0] MASK_LOGIC = 6'h0e;
  localparam logic [5:0] MASK_COMPL = 6'h0f;
  localparam logic [5:0] MASK_MUL = 6'h03;

  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;

endpackage

// ===== rtl/bal_mul_if.sv
// Carrier between the datapath and its multiplier.
// Assumes both ends sit in the same clock domain; the link is combinational.
`timescale 1ns/10ps
`default_nettype none
interface bal_mul_if;
  import bal_pkg::*;
  logic [7:0] a;
  logic [7:0] b;
  bal_mkind_t kind;
  logic [15:0] product;
  logic zero;
  logic carry;
  modport unit (input a, input b, input kind,
                output product, output zero, output carry);
  modport user (output a, output b, output kind,
                input product, input zero, input carry);
endinterface
`default_nettype wire

// ===== rtl/bal_mult.sv
// Combinational 8x8 multiplier for the byte ALU datapath.
// Assumes the caller registers the product; no state is held here.
`timescale 1ns/10ps
`default_nettype none
module bal_mult
  import bal_pkg::*;
(
  // Operands in, product out.
  bal_mul_if.unit m
);

  wire logic a_sx;
  wire logic b_sx;
  wire logic [17:0] full;
  wire logic [15:0] raw;

  // Sign extension to nine bits lets one signed multiplier serve all kinds.
  assign a_sx = (m.kind == mk_signed || m.kind == mk_mixed) & m.a[7];
  assign b_sx = (m.kind == mk_signed) & m.b[7];
  assign full = 18'($signed({a_sx, m.a}) * $signed({b_sx, m.b}));
  assign raw = full[15:0];
  // The carry is the top bit before the fractional shift drops it.
  assign m.product = (m.kind == mk_fraction) ? {raw[14:0], 1'b0} : raw;
  assign m.carry = raw[15];
  assign m.zero = (m.product == 16'h0000);

endmodule
`default_nettype wire

// ===== rtl/bal_core.sv
// Byte ALU datapath: arithmetic, logic, word and multiply operations.
// Assumes the decoder drives operands from the register file on ref_clk.
//
// Overview of operation
// - Add registers, optional carry, five flags, one clock.
// - Word plus immediate, five flags, two clocks.
// - Subtract register or constant, five flags, one clock.
// - Register subtract with borrow, five flags, one clock.
// - Constant subtract with borrow, five flags, one clock.
// - Word minus immediate, five flags, two clocks.
// - AND register or constant, Z N V, one clock.
// - OR register or constant, Z N V, one clock.
// - Set bits by OR mask, Z N V.
// - Clear bits by AND inverted mask, Z N V.
// - Test keeps value, sets Z N V.
// - Multiplies into product pair, Z C, two clocks.
`timescale 1ns/10ps
`default_nettype none
module bal_core
  import bal_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic arst_n,
  // Operation request from the decoder.
  input wire logic op_valid,
  input wire bal_op_t op_code,
  input wire logic [DATA_W-1:0] rd_val,
  input wire logic [DATA_W-1:0] rr_val,
  input wire logic [DATA_W-1:0] imm_val,
  input wire logic [WORD_W-1:0] pair_val,
  output logic op_ready,
  // Result towards the register file.
  output logic res_valid,
  output logic [WORD_W-1:0] res_data,
  output bal_dest_t res_dest,
  // Status flags.
  output logic [FLG_W-1:0] flags
);

  bal_state_t state_r, state_nxt;
  bal_op_t hold_op_r;
  logic [DATA_W-1:0] hold_rd_r, hold_rr_r, hold_imm_r;
  logic [WORD_W-1:0] hold_pair_r;
  logic res_valid_r;
  logic [WORD_W-1:0] res_data_r, res_data_nxt;
  bal_dest_t res_dest_r;
  logic [FLG_W-1:0] flags_r, flags_nxt;

  bal_mul_if mul_link ();

  bal_mult u_mult (
    .m(mul_link)
  );

  wire logic take;
  wire logic second;
  wire logic finish;
  wire bal_op_t op_cur;
  wire logic [DATA_W-1:0] rd_cur, rr_cur, imm_cur;
  wire logic [WORD_W-1:0] pair_cur;
  wire logic carry_in;

  assign op_ready = (state_r == st_idle);
  assign take = op_valid & op_ready;
  assign second = (state_r == st_second);
  // Second-cycle work reads held operands so the decoder may move on.
  assign op_cur = second ? hold_op_r : op_code;
  assign rd_cur = second ? hold_rd_r : rd_val;
  assign rr_cur = second ? hold_rr_r : rr_val;
  assign imm_cur = second ? hold_imm_r : imm_val;
  assign pair_cur = second ? hold_pair_r : pair_val;
  assign carry_in = flags_r[FLG_C];

  // Decode table.
  logic [DATA_W-1:0] a_in, b_in, logic_val;
  logic sub, cin, use_adder, long_op;
  logic [FLG_W-1:0] mask;
  bal_dest_t dest;
  bal_mkind_t mkind;

  always_comb begin
    a_in = rd_cur;
    b_in = rr_cur;
    sub = 1'b0;
    cin = 1'b0;
    use_adder = 1'b1;
    logic_val = rd_cur;
    mask = MASK_ARITH;
    dest = dst_reg;
    long_op = 1'b0;
    mkind = mk_unsigned;
    case (op_cur)
      op_add_regs: ;
      op_add_carry: cin = carry_in;
      op_word_plus_immediate: begin
        mask = MASK_WORD;
        dest = dst_pair;
        long_op = 1'b1;
      end
      op_diff_regs: sub = 1'b1;
      op_difference_immediate: begin
        sub = 1'b1;
        b_in = imm_cur;
      end
      op_difference_with_borrow: begin
        sub = 1'b1;
        cin = carry_in;
      end
      op_difference_borrow_immediate: begin
        sub = 1'b1;
        cin = carry_in;
        b_in = imm_cur;
      end
      op_word_minus_immediate: begin
        mask = MASK_WORD;
        dest = dst_pair;
        long_op = 1'b1;
      end
      op_and_regs, op_self_check_flags: begin
        use_adder = 1'b0;
        logic_val = rd_cur & ((op_cur == op_and_regs) ? rr_cur : rd_cur);
        mask = MASK_LOGIC;
      end
      op_conjunction_immediate: begin
        use_adder = 1'b0;
        logic_val = rd_cur & imm_cur;
        mask = MASK_LOGIC;
      end
      op_or_regs: begin
        use_adder = 1'b0;
        logic_val = rd_cur | rr_cur;
        mask = MASK_LOGIC;
      end
      op_disjunction_immediate, op_set_selected_bits: begin
        use_adder = 1'b0;
        logic_val = rd_cur | imm_cur;
        mask = MASK_LOGIC;
      end
      op_clear_selected_bits: begin
        use_adder = 1'b0;
        logic_val = rd_cur & (ALL_ONES - imm_cur);
        mask = MASK_LOGIC;
      end
      op_bitwise_xor_regs, op_zero_register: begin
        use_adder = 1'b0;
        logic_val = rd_cur ^ ((op_cur == op_zero_register) ? rd_cur : rr_cur);
        mask = MASK_LOGIC;
      end
      op_invert_all_bits: begin
        use_adder = 1'b0;
        logic_val = ALL_ONES - rd_cur;
        mask = MASK_COMPL;
      end
      op_arithmetic_inverse: begin
        a_in = ZERO8;
        b_in = rd_cur;
        sub = 1'b1;
      end
      op_increment, op_minus_one: begin
        b_in = ONE8;
        sub = (op_cur == op_minus_one);
        mask = MASK_LOGIC;
      end
      op_all_ones_load: begin
        use_adder = 1'b0;
        logic_val = ALL_ONES;
        mask = MASK_NONE;
      end
      op_product_unsigned, op_product_signed, op_product_mixed_sign,
      op_product_fractional: begin
        mask = MASK_MUL;
        dest = dst_product_result_pair;
        long_op = 1'b1;
        mkind = bal_mkind_t'(2'(op_cur - op_product_unsigned));
      end
      default: begin
        mask = MASK_NONE;
        dest = dst_none;
      end
    endcase
  end

  // Byte adder: a subtract adds the inverted operand and inverted borrow.
  wire logic [DATA_W-1:0] b_eff;
  wire logic c_eff;
  wire logic [DATA_W:0] sum9;
  wire logic [4:0] lo5;
  wire logic add_c, add_h, add_v;
  assign b_eff = sub ? ~b_in : b_in;
  assign c_eff = sub ? ~cin : cin;
  assign sum9 = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, c_eff};
  assign lo5 = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
  assign add_c = sum9[DATA_W] ^ sub;
  assign add_h = lo5[4] ^ sub;
  assign add_v = (a_in[7] == b_eff[7]) & (sum9[7] != a_in[7]);

  // Word adder for the pair operations; the constant is zero-extended.
  wire logic w_sub;
  wire logic [WORD_W-1:0] k_eff;
  wire logic [WORD_W:0] w_sum;
  wire logic w_c, w_v;
  assign w_sub = (op_cur == op_word_minus_immediate);
  assign k_eff = w_sub ? ~{ZERO8, imm_cur} : {ZERO8, imm_cur};
  assign w_sum = {1'b0, pair_cur} + {1'b0, k_eff} + {16'h0000, w_sub};
  assign w_c = w_sum[WORD_W] ^ w_sub;
  assign w_v = (pair_cur[15] == k_eff[15]) & (w_sum[15] != pair_cur[15]);

  assign mul_link.a = rd_cur;
  assign mul_link.b = rr_cur;
  assign mul_link.kind = mkind;

  wire logic is_mul, is_word;
  wire logic [DATA_W-1:0] res8;
  wire logic [FLG_W-1:0] nf;
  assign is_mul = (dest == dst_product_result_pair);
  assign is_word = (dest == dst_pair);
  assign res8 = use_adder ? sum9[DATA_W-1:0] : logic_val;
  assign nf[FLG_C] = is_mul ? mul_link.carry : is_word ? w_c :
                     use_adder ? add_c : 1'b1;
  assign nf[FLG_Z] = is_mul ? mul_link.zero :
                     is_word ? (w_sum[15:0] == 16'h0000) : (res8 == ZERO8);
  assign nf[FLG_N] = is_word ? w_sum[15] : res8[7];
  assign nf[FLG_V] = is_word ? w_v : (use_adder & add_v);
  assign nf[FLG_S] = nf[FLG_N] ^ nf[FLG_V];
  assign nf[FLG_H] = add_h;

  assign finish = (take & ~long_op) | second;
  assign state_nxt = (take & long_op) ? st_second : st_idle;
  // Flags outside the operation's mask are carried over untouched.
  assign flags_nxt = finish ? ((mask & nf) | (~mask & flags_r)) : flags_r;
  assign res_data_nxt = is_mul ? mul_link.product :
                        is_word ? w_sum[15:0] : {ZERO8, res8};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= st_idle;
      res_valid_r <= 1'b0;
      res_data_r <= 16'h0000;
      res_dest_r <= dst_none;
      flags_r <= FLAGS_RST;
    end else begin
      state_r <= state_nxt;
      res_valid_r <= finish;
      flags_r <= flags_nxt;
      if (finish) begin
        res_data_r <= res_data_nxt;
        res_dest_r <= dest;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_op_r <= op_add_regs;
      hold_rd_r <= 8'h00;
      hold_rr_r <= 8'h00;
      hold_imm_r <= 8'h00;
      hold_pair_r <= 16'h0000;
    end else if (take) begin
      hold_op_r <= op_code;
      hold_rd_r <= rd_val;
      hold_rr_r <= rr_val;
      hold_imm_r <= imm_val;
      hold_pair_r <= pair_val;
    end
  end

  assign res_valid = res_valid_r;
  assign res_data = res_data_r;
  assign res_dest = res_dest_r;
  assign flags = flags_r;

  add_carry_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_add_carry |=> res_valid &&
    res_data[7:0] == 8'($past(rd_val) + $past(rr_val) + $past(flags[FLG_C])))
    else $error("add with carry result wrong");
  word_plus_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_word_plus_immediate |=> !res_valid && !op_ready
    ##1 res_valid && res_dest == dst_pair &&
    res_data == 16'($past(pair_val, 2) + {8'h00, $past(imm_val, 2)}))
    else $error("word add wrong or not two cycles");
  diff_imm_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_difference_immediate |=> res_valid &&
    res_data[7:0] == 8'($past(rd_val) - $past(imm_val)) &&
    flags[FLG_C] == ($past(rd_val) < $past(imm_val)))
    else $error("subtract immediate wrong");
  borrow_reg_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_difference_with_borrow |=>
    res_data[7:0] == 8'($past(rd_val) - $past(rr_val) - $past(flags[FLG_C])))
    else $error("subtract with borrow wrong");
  word_minus_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_word_minus_immediate |-> ##2 res_valid &&
    flags[FLG_S] == (flags[FLG_N] ^ flags[FLG_V]) &&
    flags[FLG_C] == ($past(pair_val, 2) < {8'h00, $past(imm_val, 2)}) &&
    res_data == 16'($past(pair_val, 2) - {8'h00, $past(imm_val, 2)}))
    else $error("word subtract wrong");
  logic_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code inside {op_and_regs, op_conjunction_immediate,
    op_or_regs, op_disjunction_immediate} |=> !flags[FLG_V] &&
    $stable(flags[FLG_C]) && $stable(flags[FLG_H]))
    else $error("logic operation touched C or H or left V set");
  clear_bits_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_clear_selected_bits |=>
    res_data[7:0] == ($past(rd_val) & ~$past(imm_val)) &&
    flags[FLG_Z] == (res_data[7:0] == 8'h00))
    else $error("bit clear wrong");
  product_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_product_unsigned |-> ##2 res_valid &&
    res_dest == dst_product_result_pair &&
    res_data == 16'($past(rd_val, 2) * $past(rr_val, 2)))
    else $error("unsigned product wrong or not two cycles");
  negate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_arithmetic_inverse |=>
    res_data[7:0] == 8'(8'h00 - $past(rd_val)) &&
    flags[FLG_C] == ($past(rd_val) != 8'h00))
    else $error("negate wrong");
  ones_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && op_code == op_all_ones_load |=> res_data[7:0] == 8'hff &&
    flags == $past(flags))
    else $error("all ones load wrong or flags changed");

endmodule
`default_nettype wire

// ===== dv/bal_dec_model.sv
// Decoder and register-file stand-in that presents one operation a time.
// Assumes the caller enters each task just after a rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
module bal_dec_model
  import bal_pkg::*;
(
  // Clock and handshake.
  input wire logic ref_clk,
  input wire logic op_ready,
  // Request towards the datapath.
  output logic op_valid,
  output bal_op_t op_code,
  output logic [7:0] rd_val,
  output logic [7:0] rr_val,
  output logic [7:0] imm_val,
  output logic [15:0] pair_val
);
  initial begin
    op_valid = 1'b0;
    op_code = op_add_regs;
    rd_val = 8'h00;
    rr_val = 8'h00;
    imm_val = 8'h00;
    pair_val = 16'h0000;
  end

  // Holds the request until an edge at which op_ready is high.
  task automatic issue(input bal_op_t o, input logic [7:0] a,
                       input logic [7:0] b, input logic [7:0] k,
                       input logic [15:0] p);
    int n;
    n = 0;
    op_valid = 1'b1;
    op_code = o;
    rd_val = a;
    rr_val = b;
    imm_val = k;
    pair_val = p;
    while (op_ready !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    #1;
  endtask

  // Released operands flip so that a stale sample cannot pass unnoticed.
  task automatic release_bus();
    op_valid = 1'b0;
    rd_val = ~rd_val;
    rr_val = ~rr_val;
    imm_val = ~imm_val;
    pair_val = ~pair_val;
  endtask
endmodule
`default_nettype wire

// ===== dv/byte_alu_arith_logic_tb.sv
// Self-checking bench of the byte ALU datapath, one task per scenario.
// Assumes bal_core and bal_dec_model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module byte_alu_arith_logic_tb
  import bal_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid, op_ready, res_valid;
  bal_op_t op_code;
  logic [7:0] rd_val, rr_val, imm_val;
  logic [15:0] pair_val, res_data;
  bal_dest_t res_dest;
  logic [FLG_W-1:0] flags;
  logic [5:0] ef = FLAGS_RST;
  int bad_count = 0;
  int num_checks = 0;

  always #25 ref_clk = ~ref_clk;

  bal_dec_model dec (.ref_clk(ref_clk), .op_ready(op_ready),
    .op_valid(op_valid), .op_code(op_code), .rd_val(rd_val),
    .rr_val(rr_val), .imm_val(imm_val), .pair_val(pair_val));
  bal_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .rd_val(rd_val), .rr_val(rr_val),
    .imm_val(imm_val), .pair_val(pair_val), .op_ready(op_ready),
    .res_valid(res_valid), .res_data(res_data), .res_dest(res_dest),
    .flags(flags));

  // Returns {dest, flags, result} as the datapath should produce them.
  function automatic logic [23:0] model(input bal_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] k,
      input logic [15:0] p, input logic [5:0] f);
    logic [7:0] x, y, r;
    logic [8:0] s;
    logic [4:0] h;
    logic [16:0] w;
    logic [15:0] m, res;
    logic [5:0] nf, msk;
    logic [1:0] d;
    logic c, sb, ar, vv;
    x = a; y = b; c = 1'b0; sb = 1'b0; ar = 1'b0; vv = 1'b0;
    r = 8'h00; nf = f; msk = MASK_LOGIC; d = dst_reg; res = 16'h0000;
    case (op)
      op_add_regs: ar = 1'b1;
      op_add_carry: begin ar = 1'b1; c = f[0]; end
      op_diff_regs: begin ar = 1'b1; sb = 1'b1; end
      op_difference_immediate: begin ar = 1'b1; sb = 1'b1; y = k; end
      op_difference_with_borrow: begin ar = 1'b1; sb = 1'b1; c = f[0]; end
      op_difference_borrow_immediate: begin
        ar = 1'b1; sb = 1'b1; y = k; c = f[0];
      end
      op_arithmetic_inverse: begin ar = 1'b1; sb = 1'b1; x = 8'h00; y = a; end
      op_and_regs: r = a & b;
      op_conjunction_immediate: r = a & k;
      op_or_regs: r = a | b;
      op_disjunction_immediate, op_set_selected_bits: r = a | k;
      op_clear_selected_bits: r = a & (ALL_ONES - k);
      op_bitwise_xor_regs: r = a ^ b;
      op_self_check_flags: r = a;
      op_zero_register: r = a ^ a;
      op_increment: begin r = a + 8'h01; vv = (a == 8'h7f); end
      op_minus_one: begin r = a - 8'h01; vv = (a == 8'h80); end
      op_invert_all_bits: begin r = ALL_ONES - a; nf[0] = 1'b1; msk = MASK_COMPL; end
      op_all_ones_load: begin r = ALL_ONES; msk = MASK_NONE; end
      default: begin d = dst_none; msk = MASK_NONE; end
    endcase
    if (ar) begin
      s = sb ? {1'b0, x} - {1'b0, y} - {8'h00, c} : {1'b0, x} + {1'b0, y} + {8'h00, c};
      h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, c}
             : {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
      r = s[7:0];
      vv = sb ? (x[7] != y[7]) && (r[7] != x[7]) : (x[7] == y[7]) && (r[7] != x[7]);
      nf[0] = s[8];
      nf[5] = h[4];
      msk = MASK_ARITH;
    end
    res = {8'h00, r};
    nf[1] = ~|r;
    nf[2] = r[7];
    nf[3] = vv;
    if (op inside {op_word_plus_immediate, op_word_minus_immediate}) begin
      w = (op == op_word_plus_immediate) ? {1'b0, p} + {9'h000, k} : {1'b0, p} - {9'h000, k};
      res = w[15:0];
      nf[0] = w[16];
      nf[3] = (op == op_word_plus_immediate) ? ~p[15] & w[15] : p[15] & ~w[15];
      nf[2] = w[15];
      nf[4] = nf[2] ^ nf[3];
      msk = MASK_WORD;
      d = dst_pair;
    end
    if (op inside {[op_product_unsigned:op_product_fractional]}) begin
      if (op == op_product_signed) m = {{8{a[7]}}, a} * {{8{b[7]}}, b};
      else if (op == op_product_mixed_sign) m = {{8{a[7]}}, a} * {8'h00, b};
      else m = {8'h00, a} * {8'h00, b};
      res = (op == op_product_fractional) ? {m[14:0], 1'b0} : m;
      nf[0] = m[15];
      msk = MASK_MUL;
      d = dst_product_result_pair;
    end
    nf[1] = (d == dst_reg) ? ~|r : ~|res;
    return {d, (nf & msk) | (f & ~msk), res};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // With keep set the next request follows at once, in the cycle the result is seen and op_ready is high again.
  task automatic run_op(input bal_op_t o, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] k, input logic [15:0] p, input bit keep);
    logic [23:0] e;
    int cy, n;
    e = model(o, a, b, k, p, ef);
    cy = (o inside {op_word_plus_immediate, op_word_minus_immediate,
          [op_product_unsigned:op_product_fractional]}) ? 2 : 1;
    dec.issue(o, a, b, k, p);
    if (cy == 2) chk("op_ready busy", 16'h0000, {15'h0, op_ready});
    n = 1;
    while (res_valid !== 1'b1 && n < 5) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("latency", 16'(cy), 16'(n));
    chk("op_ready done", 16'h0001, {15'h0, op_ready});
    chk("res_dest", {14'h0, e[23:22]}, {14'h0, res_dest});
    chk("flags", {10'h0, e[21:16]}, {10'h0, flags});
    if (e[23:22] != dst_none) chk("res_data", e[15:0], res_data);
    ef = e[21:16];
    if (!keep) begin
      dec.release_bus();
      @(posedge ref_clk);
      #1;
      // The result strobe must drop once no further request is taken.
      chk("res_valid pulse", 16'h0000, {15'h0, res_valid});
    end
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("rst op_ready", 16'h0001, {15'h0, op_ready});
    chk("rst res_valid", 16'h0000, {15'h0, res_valid});
    chk("rst res_data", 16'h0000, res_data);
    chk("rst res_dest", {14'h0, dst_none}, {14'h0, res_dest});
    chk("rst flags", {10'h0, FLAGS_RST}, {10'h0, flags});
    ef = FLAGS_RST;
    arst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    $display("test reset done");
  endtask

  task automatic t_add();
    run_op(op_add_regs, 8'h7f, 8'h01, 8'h33, 16'h5555, 1);
    run_op(op_add_regs, 8'hff, 8'h01, 8'h33, 16'h5555, 1);
    run_op(op_add_carry, 8'h10, 8'h2f, 8'h33, 16'h5555, 0);
    $display("test add done");
  endtask

  task automatic t_sub();
    run_op(op_difference_immediate, 8'h80, 8'hc3, 8'h01, 16'h5555, 1);
    run_op(op_diff_regs, 8'h00, 8'h01, 8'h33, 16'h5555, 1);
    run_op(op_difference_with_borrow, 8'h01, 8'h00, 8'h33, 16'h5555, 1);
    run_op(op_difference_borrow_immediate, 8'h10, 8'hc3, 8'h0f, 16'h5555, 0);
    $display("test subtract done");
  endtask

  task automatic t_word();
    run_op(op_word_plus_immediate, 8'h12, 8'h34, 8'h3f, 16'hffc1, 1);
    run_op(op_word_minus_immediate, 8'h12, 8'h34, 8'h01, 16'h0000, 1);
    run_op(op_word_minus_immediate, 8'h12, 8'h34, 8'h3f, 16'h8000, 1);
    run_op(op_add_regs, 8'h01, 8'h01, 8'h33, 16'h5555, 0);
    $display("test word done");
  endtask

  task automatic t_logic();
    run_op(op_add_regs, 8'hff, 8'h01, 8'h33, 16'h5555, 1);
    run_op(op_and_regs, 8'hf0, 8'h3c, 8'h0f, 16'h5555, 1);
    run_op(op_conjunction_immediate, 8'h81, 8'h01, 8'h80, 16'h5555, 1);
    run_op(op_or_regs, 8'h00, 8'h00, 8'hff, 16'h5555, 1);
    run_op(op_disjunction_immediate, 8'h01, 8'h80, 8'h02, 16'h5555, 1);
    run_op(op_set_selected_bits, 8'h01, 8'h00, 8'h80, 16'h5555, 1);
    run_op(op_clear_selected_bits, 8'hff, 8'h00, 8'h0f, 16'h5555, 1);
    run_op(op_bitwise_xor_regs, 8'haa, 8'haa, 8'h00, 16'h5555, 1);
    run_op(op_self_check_flags, 8'h80, 8'h00, 8'h00, 16'h5555, 1);
    run_op(op_zero_register, 8'h5a, 8'h5a, 8'h5a, 16'h5555, 0);
    $display("test logic done");
  endtask

  task automatic t_unary();
    run_op(op_invert_all_bits, 8'h0f, 8'h33, 8'h33, 16'h5555, 1);
    run_op(op_arithmetic_inverse, 8'h80, 8'h33, 8'h33, 16'h5555, 1);
    run_op(op_arithmetic_inverse, 8'h00, 8'h33, 8'h33, 16'h5555, 1);
    run_op(op_increment, 8'h7f, 8'h33, 8'h33, 16'h5555, 1);
    run_op(op_minus_one, 8'h80, 8'h33, 8'h33, 16'h5555, 1);
    run_op(op_minus_one, 8'h01, 8'h33, 8'h33, 16'h5555, 1);
    run_op(op_all_ones_load, 8'h12, 8'h33, 8'h33, 16'h5555, 0);
    $display("test unary done");
  endtask

  task automatic t_mul();
    run_op(op_product_unsigned, 8'hff, 8'hff, 8'h33, 16'h5555, 1);
    run_op(op_product_signed, 8'h80, 8'h80, 8'h33, 16'h5555, 1);
    run_op(op_product_signed, 8'hff, 8'h01, 8'h33, 16'h5555, 1);
    run_op(op_product_mixed_sign, 8'hff, 8'h02, 8'h33, 16'h5555, 1);
    run_op(op_product_fractional, 8'h80, 8'h80, 8'h33, 16'h5555, 1);
    run_op(op_product_fractional, 8'hff, 8'hff, 8'h33, 16'h5555, 1);
    run_op(op_product_unsigned, 8'h00, 8'h55, 8'h33, 16'h5555, 0);
    $display("test multiply done");
  endtask

  // An unknown code must leave flags alone; a reset in mid-run follows.
  task automatic t_unknown();
    run_op(op_add_regs, 8'hff, 8'h01, 8'h33, 16'h5555, 1);
    run_op(bal_op_t'(5'h1f), 8'h01, 8'h02, 8'h03, 16'h5555, 0);
    do_reset();
    // Carry was set before the reset, so a stale flag would add one here.
    run_op(op_add_carry, 8'h10, 8'h20, 8'h33, 16'h5555, 0);
    $display("test unknown and reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(50 * 2000);
    bad_count++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    do_reset();
    t_add();
    t_sub();
    t_word();
    t_logic();
    t_unary();
    t_mul();
    t_unknown();
    wrap_up();
  end
endmodule
`default_nettype wire
